// [design/bps_defines.svh]
// Constants of the backup power sequencer: timing, offsets, fields and reset values.
`ifndef BPS_DEFINES_SVH
`define BPS_DEFINES_SVH
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BPS_CLK_MHZ 200
`define BPS_TICK_US 1000
`define BPS_TICK_CYCLES (`BPS_TICK_US * `BPS_CLK_MHZ)
`define BPS_BACKUP_MS 17'd120000
`define BPS_MIN_CHARGE_MS 17'd10000
`define BPS_LOSS_MIN_MS 12'd50
`define BPS_LOSS_MAX_MS 12'd3000
`define BPS_LOSS_DEF_MS 12'd250
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define BPS_OFS_LOSS_POS 8'h00
`define BPS_OFS_LOSS_TIME 8'h04
`define BPS_OFS_STATUS 8'h08
`define BPS_OFS_FAULT 8'h0c
// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define BPS_POS_RESET 8'h00
`define BPS_FLT_CHARGING 0
`define BPS_FLT_NO_INPUT 1
`define BPS_FLT_BACKUP 2
`define BPS_FLT_DISABLED 3
`define BPS_FLT_W 4
`define BPS_ST_STATE_LSB 0
`define BPS_ST_POWER 4
`define BPS_ST_CELL 5
`define BPS_ST_SWITCH 6
`define BPS_ST_STATUS 7
`endif

// [design/bps_pkg.sv]
// Types shared by the backup power sequencer files.
package bps_pkg;
  // Sequencer states.
  typedef enum logic [2:0] {
    BPS_WAIT,
    BPS_CHARGING,
    BPS_READY,
    BPS_QUALIFY,
    BPS_BACKUP,
    BPS_SHUTDOWN
  } bps_state_t;

  // Avalon-MM request from the master.
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } bps_avs_req_t;

  // Drive towards the actuator board.
  typedef struct packed {
    logic charge_en;
    logic pass_en;
    logic backup_en;
    logic override_en;
    logic [7:0] override_pos;
  } bps_act_t;
endpackage

// [design/bps_timer.sv]
// Saturating millisecond timer held at zero while cleared.
`timescale 1ns/1ps
module bps_timer #(
  parameter int W = 17
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Control.
  input wire logic tick,
  input wire logic clear,
  // Elapsed ticks.
  output logic [W-1:0] count
);
  logic [W-1:0] next_count;

  // Count ticks, stop at the top so a long stay never wraps.
  always_comb
  begin
    next_count = count;
    if (clear)
      next_count = '0;
    else if (tick && count != {W{1'b1}})
      next_count = count + 1'b1;
  end

  // Register the count.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      count <= '0;
    else
      count <= next_count;
  end
endmodule

// [design/bps_sticky.sv]
// Sticky flag bank, write one to clear, a set wins over a clear.
`timescale 1ns/1ps
module bps_sticky #(
  parameter int W = 4
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Events and software clear.
  input wire logic [W-1:0] set,
  input wire logic clear_we,
  input wire logic [W-1:0] clear_mask,
  // Flags.
  output logic [W-1:0] flags
);
  logic [W-1:0] next_flags;

  // Clear the masked bits, then let any event set them again.
  always_comb
  begin
    next_flags = flags;
    if (clear_we)
      next_flags = flags & ~clear_mask;
    next_flags = next_flags | set;
  end

  // Register the flags.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      flags <= '0;
    else
      flags <= next_flags;
  end
endmodule

// [design/bps_sequencer.sv]
// Backup power sequencer: charge, pass-through, loss qualification, backup and shutdown.
`timescale 1ns/1ps
`include "bps_defines.svh"
module bps_sequencer #(
  parameter int unsigned TICK_CYCLES = `BPS_TICK_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Register bus.
  input wire bps_pkg::bps_avs_req_t avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Power monitor and switch.
  input wire logic power_valid,
  input wire logic cell_full,
  input wire logic enable_switch,
  // Actuator side and status contact.
  output bps_pkg::bps_act_t act,
  output logic status_on
);
  import bps_pkg::*;

  // ----------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------
  localparam logic [17:0] TICK_LAST = 18'(TICK_CYCLES - 1);
  logic [17:0] presc;
  logic [17:0] next_presc;
  logic tick;

  // Divide the clock down to one tick per millisecond.
  always_comb
  begin
    tick = (presc == TICK_LAST);
    next_presc = tick ? 18'h0 : presc + 18'h1;
  end

  // Register the prescaler.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      presc <= 18'h0;
    else
      presc <= next_presc;
  end

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  bps_state_t state;
  bps_state_t next_state;
  logic [16:0] chg_ms;
  logic [16:0] loss_ms;
  logic [16:0] bk_ms;
  logic [11:0] loss_cfg;
  logic [7:0] loss_pos;
  logic min_done;
  logic loss_done;
  logic bk_done;

  bps_timer #(.W(17)) u_chg_timer (
    .clk(clk),
    .reset_n(reset_n),
    .tick(tick),
    .clear(state != BPS_CHARGING),
    .count(chg_ms)
  );

  // Restarted from zero on every entry into qualification.
  bps_timer #(.W(17)) u_loss_timer (
    .clk(clk),
    .reset_n(reset_n),
    .tick(tick),
    .clear(state != BPS_QUALIFY),
    .count(loss_ms)
  );

  bps_timer #(.W(17)) u_bk_timer (
    .clk(clk),
    .reset_n(reset_n),
    .tick(tick),
    .clear(state != BPS_BACKUP),
    .count(bk_ms)
  );

  // Compare elapsed times with their limits.
  assign min_done = (chg_ms >= `BPS_MIN_CHARGE_MS);
  assign loss_done = (loss_ms >= {5'h00, loss_cfg});
  assign bk_done = (bk_ms >= `BPS_BACKUP_MS);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  bps_act_t next_act;
  logic next_status_on;
  logic [`BPS_FLT_W-1:0] fault_set;
  logic [`BPS_FLT_W-1:0] fault_flags;

  // Next state, actuator drive, status contact and fault causes.
  always_comb
  begin
    next_state = state;
    unique case (state)
      BPS_WAIT:
        if (power_valid)
          next_state = BPS_CHARGING;
      BPS_CHARGING:
        if (!power_valid)
          next_state = BPS_WAIT;
        else if (cell_full && min_done)
          next_state = BPS_READY;
      BPS_READY:
        if (!power_valid)
          next_state = enable_switch ? BPS_QUALIFY : BPS_WAIT;
      BPS_QUALIFY:
        if (power_valid)
          next_state = BPS_READY;
        else if (!enable_switch)
          next_state = BPS_WAIT;
        else if (loss_done)
          next_state = BPS_BACKUP;
      BPS_BACKUP:
        if (bk_done)
          next_state = BPS_SHUTDOWN;
      BPS_SHUTDOWN:
        if (power_valid)
          next_state = BPS_CHARGING;
    endcase
    next_act.charge_en = power_valid && (next_state == BPS_CHARGING ||
      next_state == BPS_READY || next_state == BPS_QUALIFY);
    next_act.pass_en = (next_state == BPS_READY) || (next_state == BPS_QUALIFY);
    next_act.backup_en = (next_state == BPS_BACKUP);
    next_act.override_en = (next_state == BPS_BACKUP);
    next_act.override_pos = loss_pos;
    next_status_on = (next_state == BPS_READY) && enable_switch;
    fault_set = '0;
    fault_set[`BPS_FLT_CHARGING] = (next_state == BPS_CHARGING);
    fault_set[`BPS_FLT_NO_INPUT] = (next_state == BPS_WAIT) || (next_state == BPS_SHUTDOWN);
    fault_set[`BPS_FLT_BACKUP] = (next_state == BPS_QUALIFY) || (next_state == BPS_BACKUP);
    fault_set[`BPS_FLT_DISABLED] = !enable_switch && !next_status_on;
  end

  // Register state and outputs.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= BPS_WAIT;
      act <= '0;
      status_on <= 1'b0;
    end
    else
    begin
      state <= next_state;
      act <= next_act;
      status_on <= next_status_on;
    end
  end

  // ----------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------
  logic ack;
  logic next_ack;
  logic wr_fire;
  logic [31:0] next_readdata;
  logic [31:0] rd_mux;
  logic [31:0] be_mask;
  logic [31:0] loss_word;
  logic [11:0] next_loss_cfg;
  logic [7:0] next_loss_pos;

  // Wait one cycle, then release the request with data in place.
  assign avs_waitrequest = (avs_req.read || avs_req.write) && !ack;
  assign wr_fire = avs_req.write && ack;

  // Decode, read mux and register writes.
  always_comb
  begin
    be_mask = {{8{avs_req.byteenable[3]}}, {8{avs_req.byteenable[2]}},
      {8{avs_req.byteenable[1]}}, {8{avs_req.byteenable[0]}}};
    loss_word = ({20'h0, loss_cfg} & ~be_mask) | (avs_req.writedata & be_mask);
    next_ack = (avs_req.read || avs_req.write) && !ack;
    next_loss_cfg = loss_cfg;
    next_loss_pos = loss_pos;
    rd_mux = 32'h0;
    unique case (avs_req.address)
      `BPS_OFS_LOSS_POS: rd_mux = {24'h0, loss_pos};
      `BPS_OFS_LOSS_TIME: rd_mux = {20'h0, loss_cfg};
      `BPS_OFS_STATUS:
      begin
        rd_mux[`BPS_ST_STATE_LSB +: 3] = state;
        rd_mux[`BPS_ST_POWER] = power_valid;
        rd_mux[`BPS_ST_CELL] = cell_full;
        rd_mux[`BPS_ST_SWITCH] = enable_switch;
        rd_mux[`BPS_ST_STATUS] = status_on;
      end
      `BPS_OFS_FAULT: rd_mux = {28'h0, fault_flags};
      default: rd_mux = 32'h0;
    endcase
    next_readdata = (avs_req.read && !ack) ? rd_mux : avs_readdata;
    if (wr_fire && avs_req.address == `BPS_OFS_LOSS_POS && avs_req.byteenable[0])
      next_loss_pos = avs_req.writedata[7:0];
    if (wr_fire && avs_req.address == `BPS_OFS_LOSS_TIME)
    begin
      // Values outside the range are clamped to its ends.
      if (loss_word > {20'h0, `BPS_LOSS_MAX_MS})
        next_loss_cfg = `BPS_LOSS_MAX_MS;
      else if (loss_word < {20'h0, `BPS_LOSS_MIN_MS})
        next_loss_cfg = `BPS_LOSS_MIN_MS;
      else
        next_loss_cfg = loss_word[11:0];
    end
  end

  // Register bus state and configuration.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ack <= 1'b0;
      avs_readdata <= 32'h0;
      loss_cfg <= `BPS_LOSS_DEF_MS;
      loss_pos <= `BPS_POS_RESET;
    end
    else
    begin
      ack <= next_ack;
      avs_readdata <= next_readdata;
      loss_cfg <= next_loss_cfg;
      loss_pos <= next_loss_pos;
    end
  end

  // Fault flags, cleared by writing ones.
  bps_sticky #(.W(`BPS_FLT_W)) u_faults (
    .clk(clk),
    .reset_n(reset_n),
    .set(fault_set),
    .clear_we(wr_fire && avs_req.address == `BPS_OFS_FAULT && avs_req.byteenable[0]),
    .clear_mask(avs_req.writedata[`BPS_FLT_W-1:0]),
    .flags(fault_flags)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  charge_start_a: assert property ($rose(act.charge_en) |-> $past(power_valid))
    else $error("Charging began without valid input power.");
  pass_charged_a: assert property ($rose(act.pass_en) |-> $past(state) != BPS_WAIT &&
    $past(state) != BPS_SHUTDOWN)
    else $error("Pass-through opened before the charged state.");
  min_charge_a: assert property ($past(state) == BPS_CHARGING && state == BPS_READY
    |-> $past(chg_ms) >= `BPS_MIN_CHARGE_MS && $past(cell_full))
    else $error("Charged reported before the minimum charge time.");
  override_pos_a: assert property (act.backup_en |-> act.override_en &&
    act.override_pos == $past(loss_pos))
    else $error("Backup without override to the loss position.");
  backup_hold_a: assert property ($past(state) == BPS_BACKUP && state != BPS_BACKUP
    |-> $past(bk_ms) >= `BPS_BACKUP_MS ##1 !act.backup_en)
    else $error("Backup power ended early or stayed on.");
  loss_qual_a: assert property ($past(state) == BPS_QUALIFY && state == BPS_BACKUP
    |-> $past(loss_ms) >= {5'h00, $past(loss_cfg)} && !$past(power_valid))
    else $error("Backup began before the loss-detect time.");
  loss_range_a: assert property (loss_cfg >= `BPS_LOSS_MIN_MS &&
    loss_cfg <= `BPS_LOSS_MAX_MS)
    else $error("Loss-detect time outside its range.");
  disabled_a: assert property (state == BPS_READY && !enable_switch && !power_valid
    |=> state == BPS_WAIT ##1 state != BPS_BACKUP)
    else $error("Backup started with the switch at disable.");
  status_a: assert property (status_on == ($past(next_state) == BPS_READY &&
    $past(enable_switch)))
    else $error("Status contact does not follow operational state.");
  fault_a: assert property ($past(reset_n) && !status_on ##1 !status_on |-> fault_flags != '0)
    else $error("Status off without a recorded fault cause.");
  cancel_a: assert property (state == BPS_QUALIFY && power_valid |=>
    state == BPS_READY ##1 loss_ms == 17'h0)
    else $error("Returned power did not cancel qualification.");

  charged_c: cover property (state == BPS_CHARGING ##1 state == BPS_READY);
  cancel_c: cover property (state == BPS_QUALIFY ##1 state == BPS_READY);
  backup_c: cover property (state == BPS_QUALIFY ##1 state == BPS_BACKUP);
  shutdown_c: cover property (state == BPS_BACKUP ##1 state == BPS_SHUTDOWN);
endmodule

// [tb/bps_board.sv]
// Behavioural supply and reserve cell facing the backup power sequencer.
`timescale 1ns/1ps
module bps_board #(
  parameter int FILL = 400
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Bench switch and device drive.
  input wire logic supply_on,
  input wire bps_pkg::bps_act_t act,
  // Sense lines to the device.
  output logic power_valid,
  output logic cell_full
);
  import bps_pkg::*;
  int fill;
  // The supply sense follows the bench's switch with no delay.
  assign power_valid = supply_on;
  // The cell fills while charged and is emptied once it feeds the actuator.
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      fill <= 0;
    else if (act.backup_en)
      fill <= 0;
    else if (act.charge_en && fill < FILL)
      fill <= fill + 1;
  end
  // Full only after a real fill time, so the minimum charge time is exercised.
  assign cell_full = (fill >= FILL);
endmodule

// [tb/tb.sv]
// Self-checking bench of the backup power sequencer.
`timescale 1ns/1ps
`include "bps_defines.svh"
module tb;
  import bps_pkg::*;
  localparam int TK = 2;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  bps_avs_req_t req = '0;
  logic [31:0] rdata;
  logic wreq;
  logic pv;
  logic cf;
  logic en_sw = 1'b1;
  logic sup = 1'b0;
  bps_act_t act;
  logic st_on;
  int fail_count = 0;
  int compares = 0;
  int bk_seen = 0;
  logic [31:0] seed = 32'h0000005c;
  logic [31:0] rd;
  logic [7:0] pos;
  logic [31:0] lt [5];
  // ----------------------------------------------------------------
  // Clock, device and partner
  // ----------------------------------------------------------------
  // Free running 200 MHz clock.
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  bps_sequencer #(.TICK_CYCLES(TK)) dut (.clk(clk), .reset_n(reset_n), .avs_req(req),
    .avs_readdata(rdata), .avs_waitrequest(wreq), .power_valid(pv), .cell_full(cf),
    .enable_switch(en_sw), .act(act), .status_on(st_on));
  bps_board board (.clk(clk), .reset_n(reset_n), .supply_on(sup), .act(act),
    .power_valid(pv), .cell_full(cf));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // Expected loss time after a write: clamped into the legal range.
  function automatic logic [31:0] clamp(input logic [31:0] v);
    if (v < {20'h0, `BPS_LOSS_MIN_MS})
      return {20'h0, `BPS_LOSS_MIN_MS};
    if (v > {20'h0, `BPS_LOSS_MAX_MS})
      return {20'h0, `BPS_LOSS_MAX_MS};
    return v;
  endfunction
  // Expected status word for a given state code and sense levels.
  function automatic logic [31:0] st_word(input logic [2:0] s, input logic p, input logic c,
    input logic w, input logic o);
    logic [31:0] v;
    v = 32'h0;
    v[`BPS_ST_STATE_LSB +: 3] = s;
    v[`BPS_ST_POWER] = p;
    v[`BPS_ST_CELL] = c;
    v[`BPS_ST_SWITCH] = w;
    v[`BPS_ST_STATUS] = o;
    return v;
  endfunction
  // One Avalon access; the request holds until waitrequest is seen low at a rising edge.
  // Values are read right after the edge, before the design's flops update.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    req <= '{read: !wr, write: wr, address: a, byteenable: 4'hf, writedata: d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wreq !== 1'b0 && n < 50);
    if (n >= 50)
      fail_count++;
    rd = rdata;
    req <= '0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Waits some cycles and counts any cycle with backup power on.
  task automatic idle(input int n);
    repeat (n)
    begin
      @(negedge clk);
      if (act.backup_en === 1'b1)
        bk_seen++;
    end
  endtask
  // Bounded wait for pass-through (sel 0) or backup (sel 1).
  task automatic until_on(input int sel, input int lim);
    int n;
    n = 0;
    while ((sel ? act.backup_en : act.pass_en) !== 1'b1 && n < lim)
    begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic report_and_stop();
    $display("Counts: compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Watchdog: the whole run needs about 42000 cycles.
  initial
  begin
    #400000;
    fail_count++;
    report_and_stop();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  // Main sequence: defaults, clamping, charge, glitches, disable, backup.
  initial
  begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    bus(1'b0, `BPS_OFS_LOSS_TIME, 32'h0);
    chk(rd, {20'h0, `BPS_LOSS_DEF_MS});
    bus(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, `BPS_OFS_FAULT, 32'h0);
    chkb(rd[`BPS_FLT_NO_INPUT], 1'b1);
    chkb(act.charge_en, 1'b0);
    chkb(st_on, 1'b0);
    $display("test defaults done");
    seed = xs(seed);
    lt = '{32'h0, 32'h31, 32'hbb9, 32'hffff, {20'h0, seed[11:0]}};
    foreach (lt[i])
    begin
      bus(1'b1, `BPS_OFS_LOSS_TIME, lt[i]);
      bus(1'b0, `BPS_OFS_LOSS_TIME, 32'h0);
      chk(rd, clamp(lt[i]));
    end
    bus(1'b1, `BPS_OFS_LOSS_TIME, 32'h32);
    seed = xs(seed);
    pos = seed[7:0];
    bus(1'b1, `BPS_OFS_LOSS_POS, {24'h0, pos});
    $display("test loss time done");
    @(posedge clk);
    sup <= 1'b1;
    idle(4 * TK);
    chkb(act.charge_en, 1'b1);
    chkb(act.pass_en, 1'b0);
    idle(int'(`BPS_MIN_CHARGE_MS) * TK - 100);
    chkb(act.pass_en, 1'b0);
    until_on(0, 400);
    chkb(act.pass_en, 1'b1);
    chkb(st_on, 1'b1);
    bus(1'b0, `BPS_OFS_STATUS, 32'h0);
    chk(rd, st_word(3'h2, 1'b1, 1'b1, 1'b1, 1'b1));
    bus(1'b1, `BPS_OFS_FAULT, 32'hf);
    bus(1'b0, `BPS_OFS_FAULT, 32'h0);
    chk(rd, 32'h0);
    $display("test charge done");
    repeat (2)
    begin
      seed = xs(seed);
      @(posedge clk);
      sup <= 1'b0;
      idle((20 + int'(seed[4:0]) % 20) * TK);
      @(posedge clk);
      sup <= 1'b1;
      idle(10);
    end
    chk(bk_seen, 32'h0);
    chkb(act.pass_en, 1'b1);
    $display("test glitch done");
    @(posedge clk);
    en_sw <= 1'b0;
    idle(4);
    chkb(st_on, 1'b0);
    chkb(act.pass_en, 1'b1);
    chkb(act.charge_en, 1'b1);
    bus(1'b0, `BPS_OFS_FAULT, 32'h0);
    chkb(rd[`BPS_FLT_DISABLED], 1'b1);
    @(posedge clk);
    sup <= 1'b0;
    idle(100 * TK);
    chk(bk_seen, 32'h0);
    @(posedge clk);
    sup <= 1'b1;
    en_sw <= 1'b1;
    until_on(0, 21000);
    chkb(act.pass_en, 1'b1);
    $display("test disable done");
    @(posedge clk);
    sup <= 1'b0;
    idle(48 * TK);
    chkb(act.backup_en, 1'b0);
    until_on(1, 8 * TK);
    chkb(act.backup_en, 1'b1);
    chkb(act.override_en, 1'b1);
    chk({24'h0, act.override_pos}, {24'h0, pos});
    chkb(act.pass_en, 1'b0);
    chkb(st_on, 1'b0);
    @(posedge clk);
    sup <= 1'b1;
    idle(1000);
    chkb(act.backup_en, 1'b1);
    bus(1'b0, `BPS_OFS_FAULT, 32'h0);
    chkb(rd[`BPS_FLT_BACKUP], 1'b1);
    $display("test backup done");
    report_and_stop();
  end
endmodule
